// ===== design/spr_field.sv
`timescale 1ns/1ps
module spr_field
	import spr_pkg::*;
#(
	parameter int                 BYTES  = 2,
	parameter bit                 ATOMIC = 1'b0,
	parameter logic [8*BYTES-1:0] RESET  = '0
)(
	input  wire logic               clk,    // system clock
	input  wire logic               rst,    // async reset, high
	input  wire logic               wrEn,   // byte write hits field
	input  wire logic [2:0]         wrLane, // byte index in field
	input  wire logic [7:0]         wrData, // byte written
	input  wire logic [2:0]         rdLane, // byte index to read
	output logic      [7:0]         rdByte, // applied byte
	output logic      [8*BYTES-1:0] value   // applied field value
);

	// refuse byte counts that the three-bit lane index cannot serve
	if (BYTES < 1 || BYTES > 8 || (ATOMIC && BYTES < 2))
	begin : gBadBytes
		$error("spr_field: unsupported byte count");
	end

	logic [8*BYTES-1:0] value_reg, value_next;
	logic [8*BYTES-1:0] shadow_reg, shadow_next;
	wire                msbLane = (wrLane == 3'(BYTES - 1));

	// byte lane placement, lowest byte at lane 0
	always_comb
	begin
		value_next  = value_reg;
		shadow_next = shadow_reg;
		if (wrEn && 32'(wrLane) < BYTES)
		begin
			if (!ATOMIC) // [R4]
				value_next[wrLane*8 +: 8] = wrData; // [R1]
			else if (msbLane)
			begin
				for (int i = 0; i < BYTES - 1; i++)
					value_next[i*8 +: 8] = shadow_reg[i*8 +: 8]; // [R3]
				value_next[wrLane*8 +: 8] = wrData; // [R3]
			end
			else
				shadow_next[wrLane*8 +: 8] = wrData; // [R3]
		end
	end

	// field storage
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			value_reg  <= RESET;
			shadow_reg <= RESET;
		end
		else
		begin
			value_reg  <= value_next;
			shadow_reg <= shadow_next;
		end
	end

	assign value  = value_reg; // [R2]
	assign rdByte = (32'(rdLane) < BYTES) ? value_reg[rdLane*8 +: 8] : 8'h00;

endmodule // spr_field

// ===== design/spr_port_regs.sv
`timescale 1ns/1ps
module spr_port_regs
	import spr_pkg::*;
#(
	parameter int INSTANCES = BLK_COUNT
)(
	input  wire logic                   clk,          // 10 MHz clock
	input  wire logic                   rst,          // async reset
	input  wire logic                   spiMode,      // port mode, 1 = spi
	input  wire spr_wr_t                wrReq,        // byte write
	input  wire logic                   rdEn,         // byte read strobe
	input  wire logic [ADDR_W-1:0]      rdAddr,       // byte read address
	output logic      [7:0]             rdData,       // read byte, held
	output logic                        rdHit,        // read was mapped
	input  wire logic                   selectPinIn,  // enable/select pad
	input  wire logic                   sclPinIn,     // clock pad level
	output logic                        sclPinOut,    // clock pad drive
	output logic                        sclPinOe,     // clock pad enable
	input  wire logic                   sdaPinIn,     // data pad level
	output logic                        sdaPinOut,    // data pad drive
	output logic                        sdaPinOe,     // data pad enable
	input  wire logic                   sclHoldLow,   // i2c stretch
	input  wire logic                   sdaPullLow,   // i2c data low
	input  wire logic                   sdoData,      // spi data out
	input  wire logic                   sdoEnable,    // spi turn around
	output logic                        sclLevel,     // synced clock
	output logic                        sclRise,      // clock rise pulse
	output logic                        sclFall,      // clock fall pulse
	output logic                        sdaLevel,     // synced data
	output logic                        chipSelected, // spi select active
	output logic                        clkOutEnable, // all clock outputs
	output spr_pulls_t                  pulls,        // pad pull enables
	output logic                        refBufEnable, // reference buffer
	output logic                        refDcBias,    // reference bias
	output logic      [8*TRIM_BYTES-1:0] trimWord,    // non-atomic field
	output logic      [8*FREQ_BYTES-1:0] freqWord,    // atomic field
	output logic [INSTANCES-1:0][8*BLK_DIV_BYTES-1:0] blkDivider, // per block
	output logic [INSTANCES-1:0][7:0]   blkCtrl       // per block control
);

	// refuse block counts that overrun the byte address space
	if (INSTANCES < 1 ||
	    32'(BLK_BASE) + INSTANCES * 32'(BLK_STRIDE) > 256)
	begin : gBadCount
		$error("spr_port_regs: block count exceeds address space");
	end

	// address decode shared by write and read
	function automatic logic inRange(logic [7:0] a, logic [7:0] base,
	                                 int bytes);
		return (a >= base) && (32'(a) < 32'(base) + bytes);
	endfunction

	// instance index of a repeated block address
	function automatic int blkIndex(logic [7:0] a);
		return int'((a - BLK_BASE) / BLK_STRIDE);
	endfunction

	function automatic logic inBlocks(logic [7:0] a);
		return inRange(a, BLK_BASE, INSTANCES * int'(BLK_STRIDE));
	endfunction

	// lane inside one block instance
	function automatic logic [2:0] blkOfs(logic [7:0] a);
		logic [7:0] d;
		d = 8'((a - BLK_BASE) % BLK_STRIDE);
		return d[2:0];
	endfunction

	// --------------------------------------------- configuration bytes
	spr_pin_cnfg_t pinCnfg_reg;
	spr_ref_cnfg_t refCnfg_reg;
	wire pinWr = wrReq.en && wrReq.addr == PIN_CNFG_ADDR;
	wire refWr = wrReq.en && wrReq.addr == REF_CNFG_ADDR;

	// single byte configuration registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pinCnfg_reg <= spr_pin_cnfg_t'(PIN_CNFG_RST);
			refCnfg_reg <= spr_ref_cnfg_t'(REF_CNFG_RST);
		end
		else
		begin
			if (pinWr)
				pinCnfg_reg <= spr_pin_cnfg_t'(wrReq.data);
			if (refWr)
				refCnfg_reg <= spr_ref_cnfg_t'(wrReq.data);
		end
	end

	// ------------------------------------------------ multi-byte fields
	wire  trimWr = wrReq.en && inRange(wrReq.addr, TRIM_ADDR, TRIM_BYTES);
	wire  freqWr = wrReq.en && inRange(wrReq.addr, FREQ_ADDR, FREQ_BYTES);
	wire  [2:0] trimWrLane = 3'(wrReq.addr - TRIM_ADDR); // [R1]
	wire  [2:0] freqWrLane = 3'(wrReq.addr - FREQ_ADDR); // [R1]
	wire  [2:0] trimRdLane = 3'(rdAddr - TRIM_ADDR);
	wire  [2:0] freqRdLane = 3'(rdAddr - FREQ_ADDR);
	logic [7:0] trimRdByte;
	logic [7:0] freqRdByte;

	spr_field #(
		.BYTES  (TRIM_BYTES),
		.ATOMIC (1'b0),
		.RESET  (TRIM_RST)
	) trimField (
		.clk    (clk),
		.rst    (rst),
		.wrEn   (trimWr),
		.wrLane (trimWrLane),
		.wrData (wrReq.data),
		.rdLane (trimRdLane),
		.rdByte (trimRdByte),
		.value  (trimWord)
	);

	spr_field #(
		.BYTES  (FREQ_BYTES),
		.ATOMIC (1'b1),
		.RESET  (FREQ_RST)
	) freqField (
		.clk    (clk),
		.rst    (rst),
		.wrEn   (freqWr),
		.wrLane (freqWrLane),
		.wrData (wrReq.data),
		.rdLane (freqRdLane),
		.rdByte (freqRdByte),
		.value  (freqWord)
	);

	// ----------------------------------------- repeated block instances
	wire        wrInBlk  = wrReq.en && inBlocks(wrReq.addr);
	wire  [2:0] wrBlkOfs = blkOfs(wrReq.addr);
	wire  [2:0] rdBlkOfs = blkOfs(rdAddr);
	wire  [2:0] divRdLane = rdBlkOfs - BLK_DIV_OFS;
	logic [INSTANCES-1:0][7:0] divRdByte;

	// each instance carries the same register set at base + n*stride
	for (genvar n = 0; n < INSTANCES; n++)
	begin : gBlk
		wire hit   = wrInBlk && blkIndex(wrReq.addr) == n; // [R5]
		wire divWr = hit && wrBlkOfs >= BLK_DIV_OFS &&
		             32'(wrBlkOfs) < 32'(BLK_DIV_OFS) + BLK_DIV_BYTES;
		wire ctrlWr = hit && wrBlkOfs == BLK_CTRL_OFS;
		logic [7:0] ctrl_reg;

		spr_field #(
			.BYTES  (BLK_DIV_BYTES),
			.ATOMIC (1'b1),
			.RESET  (BLK_DIV_RST)
		) divField (
			.clk    (clk),
			.rst    (rst),
			.wrEn   (divWr),
			.wrLane (wrBlkOfs - BLK_DIV_OFS),
			.wrData (wrReq.data),
			.rdLane (divRdLane),
			.rdByte (divRdByte[n]),
			.value  (blkDivider[n])
		);

		// per instance control byte
		always_ff @(posedge clk or posedge rst)
		begin
			if (rst)
				ctrl_reg <= BLK_CTRL_RST;
			else if (ctrlWr)
				ctrl_reg <= wrReq.data;
		end

		assign blkCtrl[n] = ctrl_reg;
	end

	// ------------------------------------------------------- read path
	wire rdInBlk = inBlocks(rdAddr);
	wire [7:0] rdBlkIdx = 8'(blkIndex(rdAddr)); // [R5]
	logic [7:0] rdMux;
	logic       rdMapped;

	// read byte select, unmapped reads zero
	always_comb
	begin
		rdMux    = 8'h00;
		rdMapped = 1'b1;
		if (rdAddr == PIN_CNFG_ADDR)
			rdMux = {2'b00, pinCnfg_reg[5:0]};
		else if (rdAddr == REF_CNFG_ADDR)
			rdMux = {6'h00, refCnfg_reg[1:0]};
		else if (inRange(rdAddr, TRIM_ADDR, TRIM_BYTES))
			rdMux = trimRdByte;
		else if (inRange(rdAddr, FREQ_ADDR, FREQ_BYTES))
			rdMux = freqRdByte;
		else if (rdInBlk && rdBlkOfs == BLK_CTRL_OFS)
			rdMux = blkCtrl[rdBlkIdx[$clog2(INSTANCES+1)-1:0]];
		else if (rdInBlk && rdBlkOfs >= BLK_DIV_OFS &&
		         32'(rdBlkOfs) < 32'(BLK_DIV_OFS) + BLK_DIV_BYTES)
			rdMux = divRdByte[rdBlkIdx[$clog2(INSTANCES+1)-1:0]];
		else if (rdInBlk)
			rdMux = 8'h00;
		else
			rdMapped = 1'b0;
	end

	// read data held until the next read
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdData <= 8'h00;
			rdHit  <= 1'b0;
		end
		else if (rdEn)
		begin
			rdData <= rdMux;
			rdHit  <= rdMapped;
		end
	end

	// -------------------------------------------------- pin synchronisers
	logic [1:0] selSync_reg;
	logic [1:0] sclSync_reg;
	logic [1:0] sdaSync_reg;
	logic       sclLast_reg;
	logic       spiMode_reg;

	// two flops per pad, then one for edge detect
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			selSync_reg <= 2'b11;
			sclSync_reg <= 2'b11;
			sdaSync_reg <= 2'b11;
			sclLast_reg <= 1'b1;
			spiMode_reg <= 1'b0;
		end
		else
		begin
			selSync_reg <= {selSync_reg[0], selectPinIn};
			sclSync_reg <= {sclSync_reg[0], sclPinIn};
			sdaSync_reg <= {sdaSync_reg[0], sdaPinIn};
			sclLast_reg <= sclSync_reg[1];
			spiMode_reg <= spiMode; // [R13]
		end
	end

	// ------------------------------------------------ pin function mux
	wire selLevel  = selSync_reg[1];
	wire i2cMode   = !spiMode_reg; // [R13]
	wire oeFromPin = (selLevel == pinCnfg_reg.oePol); // [R6]

	assign sclLevel     = sclSync_reg[1]; // [R9]
	assign sclRise      = sclSync_reg[1] && !sclLast_reg; // [R9]
	assign sclFall      = !sclSync_reg[1] && sclLast_reg; // [R9]
	assign sdaLevel     = sdaSync_reg[1]; // [R12]
	assign chipSelected = spiMode_reg && !selLevel; // [R8]

	// clock pad: open-drain stretch in i2c, input only in spi
	assign sclPinOut = 1'b0;
	assign sclPinOe  = i2cMode && sclHoldLow; // [R9]

	// data pad: open-drain in i2c, push-pull 3-wire out in spi
	assign sdaPinOut = spiMode_reg ? sdoData : 1'b0; // [R12]
	assign sdaPinOe  = spiMode_reg ? (sdoEnable && !selLevel)
	                               : sdaPullLow; // [R12]

	// clock output enable, pulls and reference controls from flops
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			clkOutEnable <= 1'b1;
		else if (i2cMode && !pinCnfg_reg.oeSel)
			clkOutEnable <= oeFromPin; // [R6]
		else
			clkOutEnable <= 1'b1;
	end

	assign pulls.outputEnablePullup   = pinCnfg_reg.oePullup; // [R7]
	assign pulls.outputEnablePulldown = pinCnfg_reg.oePulldown; // [R7]
	assign pulls.serialClockPinPullup = pinCnfg_reg.sclPullup; // [R9]
	assign pulls.serialDataPinPullup  = pinCnfg_reg.sdaPullup; // [R12]
	assign refBufEnable = refCnfg_reg.bufEnable;
	assign refDcBias    = refCnfg_reg.dcBias;

endmodule // spr_port_regs

// ===== dv/spr_host_model.sv
`timescale 1ns/1ps
module spr_host_model
	import spr_pkg::*;
#(
	parameter int BITS = 8
)(
	input  wire logic       go,     // start one frame
	input  wire logic       spi,    // frame is spi
	input  wire logic       hostTx, // host drives data
	input  wire logic       oeLvl,  // i2c enable level
	input  wire spr_pulls_t pulls,  // device pull enables
	input  wire logic       sclOe,  // device holds clock
	input  wire logic       sdaOe,  // device drives data
	input  wire logic       sdaOut, // device data value
	output logic            sclW,   // clock wire
	output logic            sdaW,   // data wire
	output logic            selW    // select wire
);
	logic sclH = 1'b1;
	logic hostBit = 1'b1;
	logic inFrame = 1'b0;
	logic lastSda = 1'b1;
	// one frame of link clocks, still between frames
	always @(posedge go)
	begin
		inFrame = 1'b1;
		for (int i = 0; i < BITS; i++)
		begin
			sclH = 1'b0;
			hostBit = i[0];
			#400 sclH = 1'b1;
			#400;
		end
		inFrame = 1'b0;
	end
	// wires resolved from every party's drive
	assign selW = spi ? !inFrame : oeLvl;
	assign sclW = sclOe ? 1'b0 : sclH;
	always @(posedge sclH)
		lastSda <= sdaW;
	// released data line floats to pull or flips
	always @*
		sdaW = sdaOe ? sdaOut : (inFrame && hostTx) ? hostBit :
			pulls.serialDataPinPullup ? 1'b1 : !lastSda;
endmodule // spr_host_model

// ===== dv/spr_port_regs_checker.sv
`timescale 1ns/1ps
module spr_port_regs_checker
	import spr_pkg::*;
#(
	parameter int INSTANCES = BLK_COUNT
)(
	input wire logic        clk,          // clock
	input wire logic        rst,          // reset
	input wire logic        spiMode,      // port mode
	input wire spr_wr_t     wrReq,        // byte write
	input wire logic        selectPinIn,  // select pad
	input wire logic        sclHoldLow,   // clock stretch
	input wire logic        sdaPullLow,   // data low
	input wire logic        sdoData,      // spi data
	input wire logic        sdoEnable,    // spi drive
	input wire logic        sclPinOut,    // clock drive
	input wire logic        sclPinOe,     // clock enable
	input wire logic        sdaPinOut,    // data drive
	input wire logic        sdaPinOe,     // data enable
	input wire logic        chipSelected, // select active
	input wire logic        clkOutEnable, // outputs on
	input wire spr_pulls_t  pulls,        // pulls
	input wire logic [15:0] trimWord,     // trim field
	input wire logic [31:0] freqWord,     // freq field
	input wire logic [INSTANCES-1:0][15:0] blkDivider // dividers
);
	logic [7:0] pinReg;
	logic [1:0] upCnt;
	// mirror of pin byte, and settle count after reset
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			pinReg <= PIN_CNFG_RST;
			upCnt <= 2'h0;
		end
		else
		begin
			if (wrReq.en && wrReq.addr == PIN_CNFG_ADDR)
				pinReg <= wrReq.data;
			if (upCnt != 2'h3)
				upCnt <= upCnt + 2'h1;
		end
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);
	sequence freqLow;
		wrReq.en && wrReq.addr >= FREQ_ADDR &&
		wrReq.addr < FREQ_ADDR + 8'(FREQ_BYTES - 1);
	endsequence
	sequence freqTop;
		wrReq.en && wrReq.addr == FREQ_ADDR + 8'(FREQ_BYTES - 1);
	endsequence
	freq_shadow_a: assert property (freqLow |=> $stable(freqWord))
		else $error("freq low byte changed output");
	freq_apply_a: assert property (freqTop |=>
		freqWord[31:24] == $past(wrReq.data))
		else $error("freq msb not applied");
	trim_lsb_a: assert property (wrReq.en && wrReq.addr == TRIM_ADDR
		|=> trimWord[7:0] == $past(wrReq.data))
		else $error("trim low byte not applied");
	trim_msb_a: assert property (
		wrReq.en && wrReq.addr == TRIM_ADDR + 8'h01
		|=> trimWord[15:8] == $past(wrReq.data))
		else $error("trim high byte not applied");
	blk_stride_a: assert property (
		wrReq.en && wrReq.addr == BLK_BASE + BLK_STRIDE + 8'h01
		|=> blkDivider[1][15:8] == $past(wrReq.data))
		else $error("block one divider not applied");
	pull_map_a: assert property (pulls ==
		{pinReg[2], pinReg[3], pinReg[4], pinReg[5]})
		else $error("pull enables wrong");
	scl_pin_a: assert property (!sclPinOut &&
		sclPinOe == (!$past(spiMode) && sclHoldLow))
		else $error("clock pad drive wrong");
	sda_i2c_a: assert property (!$past(spiMode) |->
		sdaPinOe == sdaPullLow && !sdaPinOut)
		else $error("i2c data drive wrong");
	sda_spi_a: assert property ($past(spiMode) |->
		sdaPinOe == (sdoEnable && chipSelected) && sdaPinOut == sdoData)
		else $error("spi data drive wrong");
	chip_sel_a: assert property (chipSelected ==
		($past(spiMode) && !$past(selectPinIn, 2)))
		else $error("chip select wrong");
	out_enable_a: assert property (upCnt == 2'h3 &&
		!$past(spiMode, 2) && !pinReg[0] && $stable(pinReg)
		|-> clkOutEnable == ($past(selectPinIn, 3) == pinReg[1]))
		else $error("output enable wrong");
endmodule // spr_port_regs_checker

bind spr_port_regs spr_port_regs_checker #(.INSTANCES(INSTANCES)) chk (
	.clk, .rst, .spiMode, .wrReq, .selectPinIn, .sclHoldLow, .sdaPullLow,
	.sdoData, .sdoEnable, .sclPinOut, .sclPinOe, .sdaPinOut, .sdaPinOe,
	.chipSelected, .clkOutEnable, .pulls, .trimWord, .freqWord,
	.blkDivider);

// ===== dv/spr_port_regs_tb_top.sv
`timescale 1ns/1ps
module spr_port_regs_tb_top
	import spr_pkg::*;
;
	logic clk, rst, spiMode, rdEn, rdHit, sclPinOut, sclPinOe, sdaPinOut;
	logic sdaPinOe, sclHoldLow, sdaPullLow, sdoData, sdoEnable, sclLevel;
	logic sclRise, sclFall, sdaLevel, chipSelected, clkOutEnable;
	logic refBufEnable, refDcBias, selectPinIn, sclPinIn, sdaPinIn;
	logic go, spiF, hostTx, oeLvl;
	logic [7:0]       rdAddr, rdData;
	spr_wr_t          wrReq;
	spr_pulls_t       pulls;
	logic [15:0]      trimWord;
	logic [31:0]      freqWord;
	logic [3:0][15:0] blkDivider;
	logic [3:0][7:0]  blkCtrl;
	int fails = 0, check_count = 0, tick = 0, rises = 0, falls = 0;

	spr_port_regs uut (.clk, .rst, .spiMode, .wrReq, .rdEn, .rdAddr,
		.rdData, .rdHit, .selectPinIn, .sclPinIn, .sclPinOut, .sclPinOe,
		.sdaPinIn, .sdaPinOut, .sdaPinOe, .sclHoldLow, .sdaPullLow, .sdoData,
		.sdoEnable, .sclLevel, .sclRise, .sclFall, .sdaLevel, .chipSelected,
		.clkOutEnable, .pulls, .refBufEnable, .refDcBias, .trimWord,
		.freqWord, .blkDivider, .blkCtrl);
	spr_host_model host (.go, .spi(spiF), .hostTx, .oeLvl, .pulls,
		.sclOe(sclPinOe), .sdaOe(sdaPinOe), .sdaOut(sdaPinOut),
		.sclW(sclPinIn), .sdaW(sdaPinIn), .selW(selectPinIn));

	// clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = !clk;
	end
	// edge counts and hang guard
	always @(posedge clk)
	begin
		rises += sclRise;
		falls += sclFall;
		tick++;
		if (tick == 3000)
		begin
			fails++;
			give_verdict;
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			fails++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic waitc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		waitc(1);
		wrReq = '{1'b1, a, d};
		waitc(1);
		wrReq.en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic h);
		waitc(1);
		rdAddr = a;
		rdEn = 1'b1;
		waitc(1);
		rdEn = 1'b0;
		chk(rdData, e);
		chk(rdHit, h);
	endtask
	task automatic frame;
		go = 1'b1;
		waitc(1);
		go = 1'b0;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// test sequence
	initial
	begin
		rst = 1'b1;
		{spiMode, rdEn, sclHoldLow, sdaPullLow, sdoData, sdoEnable} = '0;
		{go, spiF, rdAddr, wrReq} = '0;
		{hostTx, oeLvl} = 2'b11;
		repeat (12) @(posedge clk);
		waitc(1);
		rst = 1'b0;
		rd(PIN_CNFG_ADDR, PIN_CNFG_RST, 1'b1);
		rd(REF_CNFG_ADDR, REF_CNFG_RST, 1'b1);
		rd(BLK_BASE, 8'h01, 1'b1);
		rd(8'h08, 8'h00, 1'b0);
		chk(pulls, 4'hb);
		$display("reset test done");
		wr(TRIM_ADDR, 8'ha5);
		chk(trimWord, 16'h00a5);
		wr(8'h03, 8'h5a);
		chk(trimWord, 16'h5aa5);
		rd(8'h03, 8'h5a, 1'b1);
		for (int i = 0; i < 3; i++)
			wr(FREQ_ADDR + 8'(i), 8'haa + 8'(i) * 8'h11);
		chk(freqWord, FREQ_RST);
		rd(FREQ_ADDR, 8'h00, 1'b1);
		wr(8'h07, 8'hdd);
		chk(freqWord, 32'hddccbbaa);
		wr(8'h07, 8'h01);
		chk(freqWord, 32'h01ccbbaa);
		$display("field test done");
		for (int n = 0; n < 4; n++)
		begin
			wr(BLK_BASE + 8'(n) * BLK_STRIDE, 8'h10 + 8'(n));
			chk(blkDivider[n], BLK_DIV_RST);
			wr(BLK_BASE + 8'(n) * BLK_STRIDE + 8'h01, 8'h20 + 8'(n));
			wr(BLK_BASE + 8'(n) * BLK_STRIDE + 8'h02, 8'h30 + 8'(n));
		end
		for (int n = 0; n < 4; n++)
		begin
			chk(blkDivider[n], {8'h20 + 8'(n), 8'h10 + 8'(n)});
			chk(blkCtrl[n], 8'h30 + 8'(n));
		end
		wr(REF_CNFG_ADDR, 8'h02);
		chk(refBufEnable, 1'b0);
		chk(refDcBias, 1'b1);
		$display("block test done");
		wr(PIN_CNFG_ADDR, 8'h08);
		chk(pulls, 4'h4);
		oeLvl = 1'b0;
		waitc(4);
		chk(clkOutEnable, 1'b1);
		oeLvl = 1'b1;
		waitc(4);
		chk(clkOutEnable, 1'b0);
		wr(PIN_CNFG_ADDR, 8'h0a);
		waitc(2);
		chk(clkOutEnable, 1'b1);
		wr(PIN_CNFG_ADDR, 8'h0b);
		oeLvl = 1'b0;
		waitc(4);
		chk(clkOutEnable, 1'b1);
		wr(PIN_CNFG_ADDR, 8'h30);
		$display("enable test done");
		rises = 0;
		falls = 0;
		frame;
		waitc(72);
		chk(rises, 8);
		chk(falls, 8);
		sclHoldLow = 1'b1;
		sdaPullLow = 1'b1;
		waitc(1);
		chk(sclPinIn, 1'b0);
		chk(sdaPinIn, 1'b0);
		// pad levels reach the core after two flops
		waitc(2);
		chk(sclLevel, 1'b0);
		chk(sdaLevel, 1'b0);
		// mode settles before the host lowers select
		{spiMode, spiF, hostTx, sdoEnable, sdoData} = 5'b11011;
		waitc(2);
		frame;
		waitc(4);
		chk(chipSelected, 1'b1);
		chk(sclPinOe, 1'b0);
		chk(sdaPinIn, 1'b1);
		chk(sdaLevel, 1'b1);
		sdoData = 1'b0;
		waitc(1);
		chk(sdaPinIn, 1'b0);
		waitc(70);
		chk(chipSelected, 1'b0);
		chk(sdaPinOe, 1'b0);
		$display("pin test done");
		give_verdict;
	end
endmodule // spr_port_regs_tb_top

// ===== pkg/spr_pkg.sv
// Function
// [R1] low byte at base, higher bytes above
// [R2] bit 0 is lsb, width minus one msb
// [R3] atomic field: shadow lower bytes, apply on msb
// [R4] non-atomic field: each byte applies at once
// [R5] block instance n at base plus n*stride
// [R6] i2c: select pin gates all clock outputs
// [R7] pin pull-up and pull-down set independently
// [R8] spi: select pin is active-low chip select
// [R9] clock pin: i2c clock or spi clock, pull-up
// [R10] software clears buffer enable when input unused
// [R11] software sets dc bias for ac coupling
// [R12] data pin: open-drain i2c or 3-wire spi
// [R13] one port mode picks all pin functions
package spr_pkg;

	localparam int ADDR_W = 8;

	// global byte map
	localparam logic [7:0] PIN_CNFG_ADDR  = 8'h00;
	localparam logic [7:0] REF_CNFG_ADDR  = 8'h01;
	localparam logic [7:0] TRIM_ADDR      = 8'h02;
	localparam int         TRIM_BYTES     = 2;
	localparam logic [7:0] FREQ_ADDR      = 8'h04;
	localparam int         FREQ_BYTES     = 4;

	// repeated output block
	localparam logic [7:0] BLK_BASE       = 8'h10;
	localparam logic [7:0] BLK_STRIDE     = 8'h08;
	localparam int         BLK_COUNT      = 4;
	localparam logic [2:0] BLK_DIV_OFS    = 3'h0;
	localparam int         BLK_DIV_BYTES  = 2;
	localparam logic [2:0] BLK_CTRL_OFS   = 3'h2;

	// reset values
	localparam logic [7:0]  PIN_CNFG_RST  = 8'h34;
	localparam logic [7:0]  REF_CNFG_RST  = 8'h01;
	localparam logic [15:0] TRIM_RST      = 16'h0000;
	localparam logic [31:0] FREQ_RST      = 32'h0000_0000;
	localparam logic [15:0] BLK_DIV_RST   = 16'h0001;
	localparam logic [7:0]  BLK_CTRL_RST  = 8'h00;

	// pin configuration byte, bit 0 is oeSel
	typedef struct packed {
		logic [1:0] spare;
		logic       sdaPullup;
		logic       sclPullup;
		logic       oePulldown;
		logic       oePullup;
		logic       oePol;
		logic       oeSel;
	} spr_pin_cnfg_t;

	// reference input byte, bit 0 is buffer enable
	typedef struct packed {
		logic [5:0] spare;
		logic       dcBias;
		logic       bufEnable;
	} spr_ref_cnfg_t;

	// pull controls driven to the pad ring
	typedef struct packed {
		logic outputEnablePullup;
		logic outputEnablePulldown;
		logic serialClockPinPullup;
		logic serialDataPinPullup;
	} spr_pulls_t;

	// byte write request from the serial core
	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} spr_wr_t;

endpackage
